/* File: pkg/fdgi_pkg.sv */
// Package for the fast level detection and gain indicator block
package fdgi_pkg;

  // ==========================================================================
  // Register offsets (byte wide registers)
  // ==========================================================================
  localparam logic [9:0] FDGI_ADDR_CFG      = 10'h104; // Enable and pin mode
  localparam logic [9:0] FDGI_ADDR_CTHR     = 10'h105; // coarse_level_threshold
  localparam logic [9:0] FDGI_ADDR_FHI_LO   = 10'h106; // fine_high_threshold low
  localparam logic [9:0] FDGI_ADDR_FHI_HI   = 10'h107; // fine_high_threshold high
  localparam logic [9:0] FDGI_ADDR_FLO_LO   = 10'h108; // fine_low_threshold low
  localparam logic [9:0] FDGI_ADDR_FLO_HI   = 10'h109; // fine_low_threshold high
  localparam logic [9:0] FDGI_ADDR_DWELL_LO = 10'h10A; // gain_raise_dwell_time low
  localparam logic [9:0] FDGI_ADDR_DWELL_HI = 10'h10B; // gain_raise_dwell_time high
  localparam logic [9:0] FDGI_ADDR_STATUS   = 10'h10C; // Live level pins, read only

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int FDGI_CFG_EN_BIT    = 0;  // Level pin enable
  localparam int FDGI_CFG_MODE_LSB  = 1;  // Mode field bits 3..1
  localparam int FDGI_CTHR_MSB      = 2;  // Coarse threshold bits 2..0
  localparam int FDGI_FINE_HI_MSB   = 4;  // Upper byte holds bits 12..8

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0]  FDGI_CFG_RST   = 8'h00;
  localparam logic [2:0]  FDGI_CTHR_RST  = 3'h0;
  localparam logic [12:0] FDGI_FHI_RST   = 13'h1FFF;
  localparam logic [12:0] FDGI_FLO_RST   = 13'h0000;
  localparam logic [15:0] FDGI_DWELL_RST = 16'h0001;

  // ==========================================================================
  // Timing (sample clock cycles)
  // ==========================================================================
  localparam int FDGI_LAT_FAST  = 2;   // Mode 000 level code latency
  localparam int FDGI_LAT_SLOW  = 6;   // Modes 001..011 level code latency
  localparam int FDGI_LAT_OVR   = 12;  // Overrange latency
  localparam int FDGI_CODE_DLY  = FDGI_LAT_SLOW - 1; // Code delay depth
  localparam int FDGI_OVR_DLY   = FDGI_LAT_OVR - 2;  // Overrange delay depth
  localparam int FDGI_NCHAN     = 2;   // Converter channels

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    FDGI_MODE_MAG4,      // 4-bit coarse code
    FDGI_MODE_MAG3_OVR,  // 3-bit code plus overrange
    FDGI_MODE_MAG2_OVR,  // 2-bit code plus fine lower
    FDGI_MODE_MAG2,      // 2-bit code plus fine lower
    FDGI_MODE_THRESH,    // Overrange, coarse, fine upper, fine lower
    FDGI_MODE_GAIN,      // Overrange, fine upper, raise, drop
    FDGI_MODE_RSV6,      // Unused code
    FDGI_MODE_RSV7       // Unused code
  } fdgi_mode_t;

  // Per-channel converter samples
  typedef struct packed {
    logic [3:0]  coarse_mag; // Early stage magnitude code 0..8
    logic [12:0] fine_mag;   // Pipeline output magnitude
    logic        ovr;        // Overrange at converter input
  } fdgi_sample_t;

  // Per-channel indicator flags
  typedef struct packed {
    logic ovr;
    logic coarse_upper_flag;
    logic fine_upper_flag;
    logic fine_lower_flag;
    logic gain_raise_flag;
    logic gain_drop_flag;
  } fdgi_flags_t;

endpackage : fdgi_pkg

/* File: rtl/fdgi_core.sv */
// Fast level detection and gain indicator logic for two converter channels
// How it works
// - mode 000 shows 4-bit code, latency two
// - 4-bit code 0000 to 1000 by level
// - modes 001-011 use subset, latency six
// - mode 001 shows 3-bit code on top
// - modes 010/011 show 2-bit code on top
// - mode field routes flags onto pins
// - mode bits 3..1 plus enable bit
// - each channel has own four pins
// - comparisons use magnitude, sign ignored
// - overrange appears twelve cycles after event
// - gain flags available in mode 101 only
// - coarse flag when code exceeds threshold
// - coarse flag holds at least two cycles
// - threshold codes map to coarse levels
// - fine upper flag above 13-bit threshold
// - fine lower flag below 13-bit threshold
// - drop flag when above coarse threshold
// - raise flag after dwell below lower threshold
// - flags follow samples, hold two cycles
`timescale 1ns/1ns
module fdgi_core
  import fdgi_pkg::*;
(
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  // Register port
  input  wire logic                          reg_wr_en,
  input  wire logic [9:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  output logic      [7:0]                    reg_rdata,
  // Converter samples
  input  wire fdgi_sample_t [FDGI_NCHAN-1:0] sample,
  // Level pins
  output logic      [FDGI_NCHAN-1:0][3:0]    fast_level_pins
);

  // ==========================================================================
  // Helper functions
  // ==========================================================================

  // Next state of a flag with a two-cycle minimum high time
  function automatic logic [1:0] hold2(input logic raw, input logic flag_q);
    logic [1:0] r;
    r[1] = raw;
    r[0] = raw & ~flag_q;
    return r;
  endfunction : hold2

  // Saturate the 4-bit coarse code into three bits
  function automatic logic [2:0] sat3(input logic [3:0] code);
    logic [2:0] r;
    r = (code > 4'h7) ? 3'h7 : code[2:0];
    return r;
  endfunction : sat3

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  logic             en_q;        // Level pin enable
  fdgi_mode_t       mode_q;      // Level pin mode
  logic [2:0]       cthr_q;      // Coarse threshold code
  logic [12:0]      fhi_q;       // Fine upper threshold
  logic [12:0]      flo_q;       // Fine lower threshold
  logic [15:0]      dwell_q;     // Raise gain dwell time

  // Register writes
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      en_q    <= FDGI_CFG_RST[FDGI_CFG_EN_BIT];
      mode_q  <= fdgi_mode_t'(FDGI_CFG_RST[FDGI_CFG_MODE_LSB +: 3]);
      cthr_q  <= FDGI_CTHR_RST;
      fhi_q   <= FDGI_FHI_RST;
      flo_q   <= FDGI_FLO_RST;
      dwell_q <= FDGI_DWELL_RST;
    end
    else if (reg_wr_en)
    begin
      unique case (reg_addr)
        FDGI_ADDR_CFG:
        begin
          // Enable and mode field
          en_q   <= reg_wdata[FDGI_CFG_EN_BIT];
          mode_q <= fdgi_mode_t'(reg_wdata[FDGI_CFG_MODE_LSB +: 3]);
        end
        FDGI_ADDR_CTHR:     cthr_q        <= reg_wdata[FDGI_CTHR_MSB:0];
        FDGI_ADDR_FHI_LO:   fhi_q[7:0]    <= reg_wdata;
        FDGI_ADDR_FHI_HI:   fhi_q[12:8]   <= reg_wdata[FDGI_FINE_HI_MSB:0];
        FDGI_ADDR_FLO_LO:   flo_q[7:0]    <= reg_wdata;
        FDGI_ADDR_FLO_HI:   flo_q[12:8]   <= reg_wdata[FDGI_FINE_HI_MSB:0];
        FDGI_ADDR_DWELL_LO: dwell_q[7:0]  <= reg_wdata;
        FDGI_ADDR_DWELL_HI: dwell_q[15:8] <= reg_wdata;
        default:
        begin
          // Unmapped or read-only offsets ignore writes
        end
      endcase
    end
  end

  // Register read mux, unused bits read as zero
  always_comb
  begin
    unique case (reg_addr)
      FDGI_ADDR_CFG:      reg_rdata = {4'h0, mode_q, en_q};
      FDGI_ADDR_CTHR:     reg_rdata = {5'h00, cthr_q};
      FDGI_ADDR_FHI_LO:   reg_rdata = fhi_q[7:0];
      FDGI_ADDR_FHI_HI:   reg_rdata = {3'h0, fhi_q[12:8]};
      FDGI_ADDR_FLO_LO:   reg_rdata = flo_q[7:0];
      FDGI_ADDR_FLO_HI:   reg_rdata = {3'h0, flo_q[12:8]};
      FDGI_ADDR_DWELL_LO: reg_rdata = dwell_q[7:0];
      FDGI_ADDR_DWELL_HI: reg_rdata = dwell_q[15:8];
      FDGI_ADDR_STATUS:   reg_rdata = {fast_level_pins[1], fast_level_pins[0]};
      default:            reg_rdata = 8'h00;
    endcase
  end

  // ==========================================================================
  // Per-channel detection, one independent copy each
  // ==========================================================================
  for (genvar ch = 0; ch < FDGI_NCHAN; ch++)
  begin : g_chan

    logic [FDGI_CODE_DLY-1:0][3:0] code_dly_q; // Coarse code delay line
    logic [FDGI_OVR_DLY-1:0]       ovr_dly_q;  // Overrange delay line
    fdgi_flags_t                   flag_q;     // Held indicator flags
    fdgi_flags_t                   first_q;    // First cycle of each flag
    fdgi_flags_t                   raw;        // Unheld conditions
    logic [15:0]                   dwell_cnt_q; // Cycles spent below lower
    logic [15:0]                   dwell_lim;  // Dwell clamped to at least 1
    logic [3:0]                    pins_d;     // Next pin value
    logic [3:0]                    pins_q;     // Registered pins
    logic [2:0]                    code3;      // Slow code saturated to three bits

    // Saturated slow-path code shared by the subset modes
    assign code3 = sat3(code_dly_q[FDGI_LAT_SLOW-2]);

    // Delay lines for the level code and the overrange event
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        code_dly_q <= '0;
        ovr_dly_q  <= '0;
      end
      else
      begin
        code_dly_q <= {code_dly_q[FDGI_CODE_DLY-2:0], sample[ch].coarse_mag};
        ovr_dly_q  <= {ovr_dly_q[FDGI_OVR_DLY-2:0], sample[ch].ovr};
      end
    end

    // Raw threshold conditions, magnitudes only so sign has no effect
    always_comb
    begin
      raw                   = '0;
      raw.ovr               = ovr_dly_q[FDGI_OVR_DLY-1];
      // Code above threshold code; code steps match threshold steps
      raw.coarse_upper_flag = sample[ch].coarse_mag > {1'b0, cthr_q};
      raw.fine_upper_flag   = sample[ch].fine_mag > fhi_q;
      raw.fine_lower_flag   = sample[ch].fine_mag < flo_q;
      raw.gain_drop_flag    = raw.coarse_upper_flag;
      raw.gain_raise_flag   = raw.fine_lower_flag
                              && (dwell_cnt_q >= dwell_lim);
    end

    // A zero dwell behaves as one cycle
    assign dwell_lim = (dwell_q == 16'h0000) ? 16'h0001 : dwell_q;

    // Dwell counter: counts consecutive samples below the lower threshold
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        dwell_cnt_q <= '0;
      end
      else if (!raw.fine_lower_flag)
      begin
        // Any sample at or above the threshold restarts the wait
        dwell_cnt_q <= '0;
      end
      else if (dwell_cnt_q != 16'hFFFF)
      begin
        // Saturate rather than wrap
        dwell_cnt_q <= dwell_cnt_q + 16'h0001;
      end
    end

    // Flag registers with a two-cycle minimum high time
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        flag_q  <= '0;
        first_q <= '0;
      end
      else
      begin
        // Flag stays on its first cycle's successor regardless of level
        {flag_q.ovr, first_q.ovr} <= hold2(raw.ovr | first_q.ovr, flag_q.ovr);
        {flag_q.coarse_upper_flag, first_q.coarse_upper_flag} <=
          hold2(raw.coarse_upper_flag | first_q.coarse_upper_flag,
                flag_q.coarse_upper_flag);
        {flag_q.fine_upper_flag, first_q.fine_upper_flag} <=
          hold2(raw.fine_upper_flag | first_q.fine_upper_flag,
                flag_q.fine_upper_flag);
        {flag_q.fine_lower_flag, first_q.fine_lower_flag} <=
          hold2(raw.fine_lower_flag | first_q.fine_lower_flag,
                flag_q.fine_lower_flag);
        {flag_q.gain_raise_flag, first_q.gain_raise_flag} <=
          hold2(raw.gain_raise_flag | first_q.gain_raise_flag,
                flag_q.gain_raise_flag);
        {flag_q.gain_drop_flag, first_q.gain_drop_flag} <=
          hold2(raw.gain_drop_flag | first_q.gain_drop_flag,
                flag_q.gain_drop_flag);
      end
    end

    // Pin routing by mode
    always_comb
    begin
      pins_d = 4'h0;
      if (en_q)
      begin
        unique case (mode_q)
          FDGI_MODE_MAG4:
          begin
            // Full code after one delay stage plus the pin register
            pins_d = code_dly_q[FDGI_LAT_FAST-2];
          end
          FDGI_MODE_MAG3_OVR:
          begin
            // Saturated 3-bit code on the top pins, overrange below
            pins_d = {code3, flag_q.ovr};
          end
          FDGI_MODE_MAG2_OVR, FDGI_MODE_MAG2:
          begin
            // Two-bit code drops the least bit, fine lower below
            pins_d = {code3[2:1], 1'b0, flag_q.fine_lower_flag};
          end
          FDGI_MODE_THRESH:
          begin
            pins_d = {flag_q.ovr, flag_q.coarse_upper_flag,
                      flag_q.fine_upper_flag, flag_q.fine_lower_flag};
          end
          FDGI_MODE_GAIN:
          begin
            pins_d = {flag_q.ovr, flag_q.fine_upper_flag,
                      flag_q.gain_raise_flag, flag_q.gain_drop_flag};
          end
          default:
          begin
            // Unused mode codes drive all pins low
            pins_d = 4'h0;
          end
        endcase
      end
    end

    // Output register for the four pins
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        pins_q <= 4'h0;
      end
      else
      begin
        pins_q <= pins_d;
      end
    end

    assign fast_level_pins[ch] = pins_q;

  end : g_chan

endmodule : fdgi_core

/* File: tb/fdgi_gain_ctrl.sv */
// Model of external gain control driving an attenuator
`timescale 1ns/1ns
module fdgi_gain_ctrl
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Gain indicator pins
  input  wire logic drop,
  input  wire logic raise,
  // Attenuator control
  output logic      atten_q
);
  // Attenuate at once on drop, release only on dwell-qualified raise
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      atten_q <= 1'b0;
    else if (drop)
      atten_q <= 1'b1;
    else if (raise)
      atten_q <= 1'b0;
endmodule : fdgi_gain_ctrl

/* File: tb/fdgi_core_props.sv */
// Checker for the level pins of the fast level block
`timescale 1ns/1ns
module fdgi_core_props
  import fdgi_pkg::*;
(
  // Clock and reset
  input wire logic                          sys_clk,
  input wire logic                          sys_rst,
  // Register port
  input wire logic                          reg_wr_en,
  input wire logic [9:0]                    reg_addr,
  input wire logic [7:0]                    reg_wdata,
  input wire logic [7:0]                    reg_rdata,
  // Samples and pins
  input wire fdgi_sample_t [FDGI_NCHAN-1:0] sample,
  input wire logic [FDGI_NCHAN-1:0][3:0]    fast_level_pins
);
  // ========
  // Shadow registers
  logic [7:0]  rg_q [8]; // Copy of 0x104..0x10B
  logic [3:0]  age_q;    // Cycles since reset or write
  logic [15:0] low_q;    // Consecutive low samples
  logic        wr_hit;   // Write to a mapped register
  logic        ok;       // Settled long enough to judge
  logic [2:0]  md;       // Pin mode
  logic [2:0]  cthr;     // Coarse threshold
  logic [12:0] fhi;      // Fine upper threshold
  logic [12:0] flo;      // Fine lower threshold
  assign wr_hit = reg_wr_en && reg_addr >= FDGI_ADDR_CFG && reg_addr <= FDGI_ADDR_DWELL_HI;
  assign ok     = age_q >= 4'hD && rg_q[0][0];
  assign md     = rg_q[0][3:1];
  assign cthr   = rg_q[1][2:0];
  assign fhi    = {rg_q[3][4:0], rg_q[2]};
  assign flo    = {rg_q[5][4:0], rg_q[4]};
  // Track register writes and settle time
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      rg_q  <= '{8'h00, 8'h00, 8'hFF, 8'h1F, 8'h00, 8'h00, 8'h01, 8'h00};
      age_q <= 4'h0;
    end
    else if (wr_hit)
    begin
      rg_q[3'(reg_addr - FDGI_ADDR_CFG)] <= reg_wdata;
      age_q                              <= 4'h0;
    end
    else if (age_q != 4'hF)
      age_q <= age_q + 4'h1;
  // Count low samples on channel 0
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      low_q <= 16'h0000;
    else
      low_q <= (sample[0].fine_mag < flo) ? low_q + 16'(low_q != 16'hFFFF) : 16'h0000;
  // ========
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_coarse_hi;
    ok && sample[0].coarse_mag > {1'b0, cthr};
  endsequence
  sequence s_held;
    ##2 (!ok || fast_level_pins[0][2]);
  endsequence
  AST_OFF: assert property (age_q >= 4'hD && (!rg_q[0][0] || md[2:1] == 2'b11) |-> fast_level_pins == '0)
    else $error("pins active while disabled");
  AST_MAG4: assert property (ok && md == 3'h0 |-> fast_level_pins == {$past(sample[1].coarse_mag, 2), $past(sample[0].coarse_mag, 2)})
    else $error("fast code wrong");
  AST_MAG3: assert property (ok && md == 3'h1 && $past(sample[0].coarse_mag, 6) < 4'h8 |-> fast_level_pins[0][3:1] == $past(sample[0].coarse_mag[2:0], 6))
    else $error("three bit code wrong");
  AST_OVR: assert property (ok && md == 3'h1 && $past(sample[0].ovr, 12) |-> fast_level_pins[0][0])
    else $error("overrange missing");
  AST_CUT: assert property (s_coarse_hi and md == 3'h4 |-> s_held)
    else $error("coarse flag missing");
  AST_CUT_HOLD: assert property (ok && md == 3'h4 && $rose(fast_level_pins[0][2]) |=> !ok || fast_level_pins[0][2])
    else $error("coarse flag too short");
  AST_FLT: assert property (ok && md == 3'h4 && sample[0].fine_mag < flo |-> ##2 (!ok || fast_level_pins[0][0]))
    else $error("fine lower missing");
  AST_FUT: assert property (ok && md == 3'h5 && sample[0].fine_mag > fhi |-> s_held)
    else $error("fine upper missing");
  AST_DROP: assert property (s_coarse_hi and md == 3'h5 |-> ##2 (!ok || fast_level_pins[0][0]))
    else $error("drop flag missing");
  AST_RAISE: assert property (ok && md == 3'h5 && $rose(fast_level_pins[0][1]) |-> $past(low_q) > {rg_q[7], rg_q[6]})
    else $error("raise before dwell");
endmodule : fdgi_core_props

bind fdgi_core fdgi_core_props u_props (.sys_clk, .sys_rst, .reg_wr_en, .reg_addr, .reg_wdata,
  .reg_rdata, .sample, .fast_level_pins);

/* File: tb/fdgi_core_tb_top.sv */
// Testbench for the fast level detection block
`timescale 1ns/1ns
module fdgi_core_tb_top
  import fdgi_pkg::*;
;
  // ========
  // Signals
  logic                          sys_clk;
  logic                          sys_rst;
  logic                          reg_wr_en;
  logic [9:0]                    reg_addr;
  logic [7:0]                    reg_wdata;
  logic [7:0]                    reg_rdata;
  fdgi_sample_t [FDGI_NCHAN-1:0] sample;
  logic [FDGI_NCHAN-1:0][3:0]    fast_level_pins;
  logic                          atten_q;
  logic [7:0]                    rv [8] = '{8'h00, 8'h00, 8'hFF, 8'h1F, 8'h00, 8'h00, 8'h01, 8'h00};
  int                            n_mismatch;
  int                            n_tests;
  int                            k;
  int                            m;
  fdgi_core uut (.sys_clk, .sys_rst, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata, .sample,
    .fast_level_pins);
  fdgi_gain_ctrl u_gain (.sys_clk, .sys_rst, .drop(fast_level_pins[0][0]),
    .raise(fast_level_pins[0][1]), .atten_q);
  // 20 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ========
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    tick(1);
    reg_wr_en = 1'b0;
    // Let an edge pass so back-to-back writes never toggle the strobe in one step
    tick(1);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    reg_addr = a;
    tick(1);
    chk(reg_rdata, exp);
  endtask : rd
  task automatic put(input logic [3:0] c, input logic [12:0] f, input logic o);
    sample[0] = '{c, f, o};
    sample[1] = '{4'h8 - c, 13'h0000, 1'b0};
  endtask : put
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // ========
  // Main sequence
  initial
  begin
    n_mismatch = 0;
    n_tests    = 0;
    sys_rst    = 1'b1;
    reg_wr_en  = 1'b0;
    reg_addr   = 10'h000;
    reg_wdata  = 8'h00;
    put(4'h0, 13'h0000, 1'b0);
    tick(20);
    sys_rst = 1'b0;
    chk(fast_level_pins, 8'h00);
    for (k = 0; k < 8; k++)
      rd(FDGI_ADDR_CFG + 10'(k), rv[k]);
    wr(FDGI_ADDR_CFG, 8'hFF);
    rd(FDGI_ADDR_CFG, 8'h0F);
    wr(FDGI_ADDR_FHI_HI, 8'hFF);
    rd(FDGI_ADDR_FHI_HI, 8'h1F);
    wr(FDGI_ADDR_STATUS, 8'h55);
    rd(FDGI_ADDR_STATUS, 8'h00);
    wr(10'h110, 8'hAA);
    rd(10'h110, 8'h00);
    // Fast code, both channels
    wr(FDGI_ADDR_CFG, 8'h01);
    for (k = 0; k < 9; k++)
    begin
      put(4'(k), 13'h0000, 1'b0);
      tick(2);
      chk(fast_level_pins, {4'h8 - 4'(k), 4'(k)});
    end
    rd(FDGI_ADDR_STATUS, 8'h08);
    // Three bit code and overrange
    wr(FDGI_ADDR_CFG, 8'h03);
    for (k = 0; k < 9; k++)
    begin
      put(4'(k), 13'h0000, 1'b0);
      tick(6);
      chk({4'h0, fast_level_pins[0]}, {4'h0, (k > 7) ? 3'h7 : 3'(k), 1'b0});
    end
    put(4'h0, 13'h0000, 1'b1);
    tick(1);
    put(4'h0, 13'h0000, 1'b0);
    tick(10);
    chk({7'h00, fast_level_pins[0][0]}, 8'h00);
    tick(1);
    chk({7'h00, fast_level_pins[0][0]}, 8'h01);
    tick(1);
    chk({7'h00, fast_level_pins[0][0]}, 8'h01);
    // Two bit code with fine lower flag
    wr(FDGI_ADDR_FLO_LO, 8'h64);
    for (m = 2; m < 4; m++)
    begin
      wr(FDGI_ADDR_CFG, {4'h0, 3'(m), 1'b1});
      for (k = 0; k < 9; k++)
      begin
        put(4'(k), k[0] ? 13'h0032 : 13'h00C8, 1'b0);
        tick(6);
        chk({4'h0, fast_level_pins[0]}, {4'h0, (k > 7) ? 2'h3 : 2'(k >> 1), 1'b0, k[0]});
      end
    end
    // Threshold flags
    wr(FDGI_ADDR_CFG, 8'h09);
    wr(FDGI_ADDR_CTHR, 8'h03);
    wr(FDGI_ADDR_FHI_LO, 8'hE8);
    wr(FDGI_ADDR_FHI_HI, 8'h03);
    // Settle below the coarse and fine upper thresholds and above the fine lower one so each flag rises on the stimulus edge
    put(4'h0, 13'h00C8, 1'b0);
    tick(14);
    put(4'h4, 13'h03E9, 1'b0);
    tick(1);
    put(4'h0, 13'h03E8, 1'b0);
    tick(1);
    chk({4'h0, fast_level_pins[0]}, 8'h06);
    tick(1);
    chk({4'h0, fast_level_pins[0]}, 8'h06);
    tick(1);
    chk({4'h0, fast_level_pins[0]}, 8'h00);
    put(4'h0, 13'h0063, 1'b0);
    tick(2);
    chk({4'h0, fast_level_pins[0]}, 8'h01);
    put(4'h0, 13'h0064, 1'b0);
    tick(3);
    chk({4'h0, fast_level_pins[0]}, 8'h00);
    for (k = 0; k < 8; k++)
    begin
      wr(FDGI_ADDR_CTHR, 8'(k));
      put(4'(k), 13'h00C8, 1'b0);
      tick(8);
      chk({4'h0, fast_level_pins[0]}, 8'h00);
      put(4'(k + 1), 13'h00C8, 1'b0);
      tick(8);
      chk({4'h0, fast_level_pins[0]}, 8'h04);
    end
    // Mid-run reset, then gain mode with dwell three
    put(4'h0, 13'h00C8, 1'b0);
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    chk(fast_level_pins, 8'h00);
    chk({7'h00, atten_q}, 8'h00);
    rd(FDGI_ADDR_FHI_LO, 8'hFF);
    wr(FDGI_ADDR_CFG, 8'h0B);
    wr(FDGI_ADDR_DWELL_LO, 8'h03);
    wr(FDGI_ADDR_CTHR, 8'h03);
    wr(FDGI_ADDR_FLO_LO, 8'h64);
    wr(FDGI_ADDR_FHI_LO, 8'hE8);
    wr(FDGI_ADDR_FHI_HI, 8'h03);
    tick(14);
    put(4'h4, 13'h07D0, 1'b0);
    tick(4);
    chk({4'h0, fast_level_pins[0]}, 8'h05);
    tick(1);
    chk({7'h00, atten_q}, 8'h01);
    put(4'h0, 13'h0032, 1'b0);
    k = 0;
    while (k < 12 && fast_level_pins[0][1] !== 1'b1)
    begin
      tick(1);
      k++;
    end
    chk(8'(k), 8'h05);
    chk({4'h0, fast_level_pins[0]}, 8'h02);
    tick(1);
    chk({7'h00, atten_q}, 8'h00);
    print_verdict();
  end
endmodule : fdgi_core_tb_top
